// ===== design/usp_pkg.sv
// Package for the serial port data path: register map, fields, frame constants
package usp_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [3:0] ADR_DATA      = 4'h0;
    localparam logic [3:0] ADR_STATUS    = 4'h4;
    localparam logic [3:0] ADR_CONTROL   = 4'h8;
    localparam logic [3:0] ADR_FORMAT    = 4'hc;
    localparam logic [3:0] ADR_IRQ       = 4'h0;

    // Status register bit positions
    localparam int ST_RX_COMPLETE = 7;
    localparam int ST_TX_COMPLETE = 6;
    localparam int ST_TX_EMPTY    = 5;
    localparam int ST_FRAME_ERR   = 4;
    localparam int ST_OVERRUN     = 3;
    localparam int ST_PARITY_ERR  = 2;

    // Control register bit positions
    localparam int CT_RX_IRQ_EN   = 7;
    localparam int CT_TXC_IRQ_EN  = 6;
    localparam int CT_TXE_IRQ_EN  = 5;
    localparam int CT_RX_EN       = 4;
    localparam int CT_TX_EN       = 3;
    localparam int CT_SIZE_HIGH   = 2;
    localparam int CT_RX_NINTH    = 1;
    localparam int CT_TX_NINTH    = 0;

    // Format register bit positions
    localparam int FM_SYNC        = 6;
    localparam int FM_PAR_HIGH    = 5;
    localparam int FM_PAR_ODD     = 4;
    localparam int FM_TWO_STOP    = 3;
    localparam int FM_SIZE_LO     = 1;

    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] FORMAT_RST  = 8'h06;

    // Character size code for nine data bits
    localparam logic [2:0] SIZE_NINE   = 3'h7;

    // Receive FIFO depth in characters
    localparam int RX_DEPTH = 2;

    // Bit clock timing: baud tick period
    localparam int BAUD_DIV_RST = 16'h0068;

    // Receive FIFO entry
    typedef struct packed {
        logic       ninth;
        logic       frame_err;
        logic       overrun;
        logic       parity_err;
        logic [7:0] data;
    } usp_rx_entry_type;

    // Transmit pending character
    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } usp_tx_char_type;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_SHIFT = 4'b0100,
        TX_STOP  = 4'b1000
    } usp_tx_state_type;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_SHIFT = 4'b0100,
        RX_STOP  = 4'b1000
    } usp_rx_state_type;

endpackage

// ===== design/usp_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module usp_sync3
    import usp_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Async input and filtered level
    input  wire logic async_i,
    output logic      level_o
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff   <= RST_VAL;
            s2_ff   <= RST_VAL;
            s3_ff   <= RST_VAL;
            level_o <= RST_VAL;
        end else begin
            s1_ff <= async_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // A change only counts once the second and third stage agree
            if (s2_ff == s3_ff) begin
                level_o <= s3_ff;
            end
        end
    end

endmodule

// ===== design/usp_top.sv
// Serial port transmit and receive data path with Wishbone register access
// Overview of operation
// - Transmit-empty flag high while buffer empty
// - Data write loads buffer only while transmitter enabled, clears empty flag
// - Empty interrupt requested while flag set
// - Complete flag set when shifter and buffer empty
// - Complete flag cleared by interrupt or write-one
// - Complete interrupt requested when flag set
// - Parity inserted after data when enabled
// - Transmitter disable waits for pending frames
// - Disabled transmitter releases the output pin
// - Receiver enable takes the input pin only
// - Frame begins only on valid start bit
// - Second stop bit is ignored
// - First stop bit moves frame to buffer
// - Unused upper data bits read zero
// - Ninth bit and errors stored per entry
// - Shifter loads when idle or after stop
// - Start, 5-9 data LSB first, parity, stops
// - Receive flag shows unread data, disable flushes
// - Overrun when buffer full, shifter full, start
`timescale 1ns/1ns
module usp_top
    import usp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Interrupt requests and global enable
    input  wire logic        global_irq_en_i,
    input  wire logic        txc_irq_taken_i,
    output logic             txe_irq_o,
    output logic             txc_irq_o,
    output logic             rxc_irq_o,
    // Serial pins
    input  wire logic        serial_in_pin_i,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe_o,
    output logic             serial_in_pin_own_o,
    input  wire logic        sync_clock_pin_i,
    input  wire logic        baud_tick_i
);

    // Registers
    logic [7:0]       port_control_reg_ff;
    logic [7:0]       format_reg_ff;
    usp_tx_char_type  tx_buf_ff;
    logic             tx_buf_full_ff;
    logic             tx_complete_flag_ff;
    logic             tx_active_ff;
    usp_tx_state_type tx_state_ff;
    logic [8:0]       tx_shift_ff;
    logic [3:0]       tx_cnt_ff;
    logic             tx_par_ff;
    logic             tx_line_ff;
    usp_rx_state_type rx_state_ff;
    logic [8:0]       rx_shift_ff;
    logic [3:0]       rx_cnt_ff;
    logic             rx_par_ff;
    logic             rx_hold_ff;
    usp_rx_entry_type rx_hold_entry_ff;
    usp_rx_entry_type rx_fifo_ff [RX_DEPTH];
    logic             rx_rd_ptr_ff;
    logic [1:0]       rx_count_ff;
    logic             ack_ff;

    // Derived control
    logic [2:0] char_size;
    logic [3:0] nbits;
    logic       tx_en;
    logic       rx_en;
    logic       par_on;
    logic       sync_mode;
    logic       rx_level;
    logic       xck_level;
    logic       xck_prev_ff;
    logic       bit_tick;
    logic       bus_req;
    logic       wr_data;
    logic       rd_data;
    logic       wr_status;
    logic       tx_load;
    logic       tx_done;
    logic       rx_push;
    logic       rx_pop;
    usp_rx_entry_type rx_head;

    assign char_size = {port_control_reg_ff[CT_SIZE_HIGH], format_reg_ff[FM_SIZE_LO+:2]};
    // Size codes 0..3 give 5..8 bits, 7 gives nine
    assign nbits     = (char_size == SIZE_NINE) ? 4'h9 : (4'h5 + {2'h0, char_size[1:0]});
    assign tx_en     = port_control_reg_ff[CT_TX_EN];
    assign rx_en     = port_control_reg_ff[CT_RX_EN];
    assign par_on    = format_reg_ff[FM_PAR_HIGH];
    assign sync_mode = format_reg_ff[FM_SYNC];

    usp_sync3 #(.RST_VAL(1'b1)) u_rx_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (serial_in_pin_i),
        .level_o (rx_level)
    );

    usp_sync3 #(.RST_VAL(1'b0)) u_xck_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (sync_clock_pin_i),
        .level_o (xck_level)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xck_prev_ff <= 1'b0;
        end else begin
            xck_prev_ff <= xck_level;
        end
    end

    // In sync mode the external clock edge paces both directions
    assign bit_tick = sync_mode ? (xck_level & ~xck_prev_ff) : baud_tick_i;

    // Bus decode: single cycle answer, ack drops after one cycle
    assign bus_req   = cyc_i & stb_i & ~ack_ff;
    assign wr_data   = bus_req & we_i & sel_i[0] & (adr_i == ADR_DATA);
    assign rd_data   = bus_req & ~we_i & (adr_i == ADR_DATA);
    assign wr_status = bus_req & we_i & sel_i[0] & (adr_i == ADR_STATUS);
    assign ack_o     = ack_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_o  <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            if (bus_req && !we_i) begin
                case (adr_i)
                    ADR_DATA:    dat_o <= {24'h00_0000, rx_head.data};
                    ADR_STATUS:  dat_o <= {24'h00_0000, (rx_count_ff != 2'h0), tx_complete_flag_ff,
                                           ~tx_buf_full_ff, rx_head.frame_err, rx_head.overrun,
                                           rx_head.parity_err, 2'h0};
                    ADR_CONTROL: dat_o <= {24'h00_0000, port_control_reg_ff[7:2], rx_head.ninth,
                                           port_control_reg_ff[CT_TX_NINTH]};
                    ADR_FORMAT:  dat_o <= {24'h00_0000, format_reg_ff};
                    default:     dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control and format registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_control_reg_ff <= CONTROL_RST;
            format_reg_ff       <= FORMAT_RST;
        end else if (bus_req && we_i && sel_i[0]) begin
            if (adr_i == ADR_CONTROL) begin
                port_control_reg_ff <= dat_i[7:0];
            end
            if (adr_i == ADR_FORMAT) begin
                format_reg_ff <= dat_i[7:0];
            end
        end
    end

    // Transmit buffer; the ninth bit must already sit in the control register
    assign tx_load = tx_buf_full_ff && (tx_state_ff == TX_IDLE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_buf_full_ff <= 1'b0;
            tx_buf_ff      <= '0;
        end else if (wr_data && tx_en) begin
            tx_buf_ff.data  <= dat_i[7:0];
            tx_buf_ff.ninth <= port_control_reg_ff[CT_TX_NINTH];
            tx_buf_full_ff  <= 1'b1;
        end else if (tx_load) begin
            tx_buf_full_ff <= 1'b0;
        end
    end

    assign tx_done = (tx_state_ff == TX_STOP) && bit_tick && (tx_cnt_ff == 4'h0);

    // Transmit complete: set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_complete_flag_ff <= 1'b0;
        end else if (tx_done && !tx_buf_full_ff) begin
            tx_complete_flag_ff <= 1'b1;
        end else if (txc_irq_taken_i || (wr_status && dat_i[ST_TX_COMPLETE])) begin
            tx_complete_flag_ff <= 1'b0;
        end
    end

    // Transmitter state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state_ff <= TX_IDLE;
            tx_shift_ff <= 9'h000;
            tx_cnt_ff   <= 4'h0;
            tx_par_ff   <= 1'b0;
            tx_line_ff  <= 1'b1;
        end else begin
            case (tx_state_ff)
                TX_IDLE: begin
                    tx_line_ff <= 1'b1;
                    if (tx_load) begin
                        tx_shift_ff <= {tx_buf_ff.ninth, tx_buf_ff.data};
                        tx_par_ff   <= format_reg_ff[FM_PAR_ODD];
                        tx_state_ff <= TX_START;
                    end
                end
                TX_START: begin
                    if (bit_tick) begin
                        tx_line_ff  <= 1'b0;
                        tx_cnt_ff   <= nbits;
                        tx_state_ff <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (bit_tick) begin
                        if (tx_cnt_ff != 4'h0) begin
                            tx_line_ff  <= tx_shift_ff[0];
                            tx_par_ff   <= tx_par_ff ^ tx_shift_ff[0];
                            tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
                            tx_cnt_ff   <= tx_cnt_ff - 4'h1;
                        end else if (par_on && !tx_shift_ff[8]) begin
                            tx_line_ff  <= tx_par_ff;
                            tx_shift_ff <= 9'h100;
                        end else begin
                            tx_line_ff  <= 1'b1;
                            tx_cnt_ff   <= format_reg_ff[FM_TWO_STOP] ? 4'h1 : 4'h0;
                            tx_state_ff <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (bit_tick) begin
                        if (tx_cnt_ff != 4'h0) begin
                            tx_cnt_ff <= tx_cnt_ff - 4'h1;
                        end else begin
                            tx_state_ff <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    // Pin ownership stays until shifter and buffer are drained
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_active_ff <= 1'b0;
        end else if (tx_en) begin
            tx_active_ff <= 1'b1;
        end else if (!tx_buf_full_ff && tx_state_ff == TX_IDLE) begin
            tx_active_ff <= 1'b0;
        end
    end

    assign serial_out_pin_o    = tx_line_ff;
    assign serial_out_pin_oe_o = tx_active_ff;
    assign serial_in_pin_own_o = rx_en;

    // Receiver: bits sampled on each tick after a valid start
    logic rx_frame_end;
    logic rx_stop_ok;
    assign rx_frame_end = (rx_state_ff == RX_STOP) && bit_tick;
    assign rx_stop_ok   = rx_level;

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_en) begin
            rx_state_ff <= RX_IDLE;
            rx_shift_ff <= 9'h000;
            rx_cnt_ff   <= 4'h0;
            rx_par_ff   <= 1'b0;
        end else begin
            case (rx_state_ff)
                RX_IDLE: begin
                    if (!rx_level) begin
                        rx_state_ff <= RX_START;
                    end
                end
                RX_START: begin
                    if (bit_tick) begin
                        if (!rx_level) begin
                            rx_state_ff <= RX_SHIFT;
                            rx_cnt_ff   <= nbits;
                            rx_shift_ff <= 9'h000;
                            rx_par_ff   <= format_reg_ff[FM_PAR_ODD];
                        end else begin
                            rx_state_ff <= RX_IDLE;
                        end
                    end
                end
                RX_SHIFT: begin
                    if (bit_tick) begin
                        if (rx_cnt_ff != 4'h0) begin
                            rx_shift_ff <= {rx_level, rx_shift_ff[8:1]};
                            rx_par_ff   <= rx_par_ff ^ rx_level;
                            rx_cnt_ff   <= rx_cnt_ff - 4'h1;
                            if (rx_cnt_ff == 4'h1 && !par_on) begin
                                rx_state_ff <= RX_STOP;
                            end
                        end else begin
                            rx_par_ff   <= rx_par_ff ^ rx_level;
                            rx_state_ff <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is examined
                    if (bit_tick) begin
                        rx_state_ff <= RX_IDLE;
                    end
                end
                default: rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    // Align received bits to bit zero and mask unused upper bits
    logic [8:0] rx_aligned;
    assign rx_aligned = rx_shift_ff >> (4'h9 - nbits);

    // Completed frame waits in the shift holding slot until the FIFO has room
    assign rx_pop  = rd_data && (rx_count_ff != 2'h0);
    assign rx_push = rx_hold_ff && (rx_count_ff != 2'(RX_DEPTH) || rx_pop);

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_en) begin
            rx_hold_ff       <= 1'b0;
            rx_hold_entry_ff <= '0;
        end else if (rx_frame_end) begin
            rx_hold_ff                  <= 1'b1;
            rx_hold_entry_ff.data       <= rx_aligned[7:0];
            rx_hold_entry_ff.ninth      <= (nbits == 4'h9) & rx_aligned[8];
            rx_hold_entry_ff.frame_err  <= ~rx_stop_ok;
            rx_hold_entry_ff.parity_err <= par_on & rx_par_ff;
            rx_hold_entry_ff.overrun    <= rx_hold_ff && !rx_push;
        end else begin
            if (rx_push) begin
                rx_hold_ff <= 1'b0;
            end
            if (rx_state_ff == RX_START && bit_tick && !rx_level && rx_hold_ff && !rx_push) begin
                rx_hold_entry_ff.overrun <= 1'b1;
            end
        end
    end

    // Two-entry receive FIFO; reads advance it
    logic rx_wr_ptr;
    assign rx_wr_ptr = rx_rd_ptr_ff ^ rx_count_ff[0];
    assign rx_head   = (rx_count_ff != 2'h0) ? rx_fifo_ff[rx_rd_ptr_ff] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_en) begin
            rx_rd_ptr_ff <= 1'b0;
            rx_count_ff  <= 2'h0;
        end else begin
            if (rx_pop) begin
                rx_rd_ptr_ff <= ~rx_rd_ptr_ff;
            end
            rx_count_ff <= rx_count_ff + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rx_push) begin
            rx_fifo_ff[rx_wr_ptr] <= rx_hold_entry_ff;
        end
    end

    // Interrupt requests
    assign txe_irq_o = global_irq_en_i & port_control_reg_ff[CT_TXE_IRQ_EN] & ~tx_buf_full_ff;
    assign txc_irq_o = global_irq_en_i & port_control_reg_ff[CT_TXC_IRQ_EN] & tx_complete_flag_ff;
    assign rxc_irq_o = global_irq_en_i & port_control_reg_ff[CT_RX_IRQ_EN] & (rx_count_ff != 2'h0);

    // Checks
    property p_txe_after_write;
        @(posedge clk_i) disable iff (rst_i) (wr_data && tx_en) |=> (tx_buf_full_ff && !txe_irq_o);
    endproperty
    a_txe_after_write: assert property (p_txe_after_write) else $error("empty irq after write");

    property p_empty_reset;
        @(posedge clk_i) $fell(rst_i) |-> (!tx_buf_full_ff && !tx_complete_flag_ff);
    endproperty
    a_empty_reset: assert property (p_empty_reset) else $error("bad tx reset state");

    property p_txc_set;
        @(posedge clk_i) disable iff (rst_i) (tx_done && !tx_buf_full_ff) |=> tx_complete_flag_ff;
    endproperty
    a_txc_set: assert property (p_txc_set) else $error("complete not set");

    property p_txc_clear;
        @(posedge clk_i) disable iff (rst_i)
            (txc_irq_taken_i && !(tx_done && !tx_buf_full_ff)) |=> !tx_complete_flag_ff;
    endproperty
    a_txc_clear: assert property (p_txc_clear) else $error("complete not cleared");

    property p_pin_held;
        @(posedge clk_i) disable iff (rst_i) (tx_state_ff != TX_IDLE) |-> serial_out_pin_oe_o;
    endproperty
    a_pin_held: assert property (p_pin_held) else $error("pin released mid frame");

    property p_start_low;
        @(posedge clk_i) disable iff (rst_i)
            (tx_state_ff == TX_START && bit_tick) |=> (!serial_out_pin_o && tx_state_ff == TX_SHIFT);
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");

    property p_flush;
        @(posedge clk_i) disable iff (rst_i) !rx_en |=> (rx_count_ff == 2'h0);
    endproperty
    a_flush: assert property (p_flush) else $error("fifo not flushed");

    property p_frame_to_hold;
        @(posedge clk_i) disable iff (rst_i) (rx_frame_end && rx_en) |=> rx_hold_ff;
    endproperty
    a_frame_to_hold: assert property (p_frame_to_hold) else $error("frame not captured");

endmodule

// ===== sim/usp_remote.sv
// Remote serial station model: sends frames and captures frames on the line
`timescale 1ns/1ns
module usp_remote (
    // Bit timing and line
    input  wire logic clk_i,
    input  wire logic tick_i,
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;

    // Bits change just after a tick so each one stands a full tick period
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i iff tick_i);
            line_o <= bits[i];
        end
        @(posedge clk_i iff tick_i);
        line_o <= 1'b1;
    endtask

    // Start bit first, then n bits sampled on the ticks, LSB first
    task automatic grab(output logic [11:0] bits, input int n);
        bits = 12'h000;
        @(posedge clk_i iff (tick_i && !line_i));
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i iff tick_i);
            bits[i] = line_i;
        end
    endtask
endmodule

// ===== sim/usp_top_tb.sv
// Self-checking bench for the serial port data path
`timescale 1ns/1ns
module usp_top_tb
    import usp_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        gie_i = 1'b0, taken_i = 1'b0, baud_tick_i = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic        xck_i = 1'b0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o, txe_irq_o, txc_irq_o, rxc_irq_o, out_o, oe_o, own_o, rem_line;
    logic [2:0]  tick_cnt = 3'h0;
    logic [7:0]  q;
    int          fails = 0;
    int          n_tests = 0;

    usp_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .global_irq_en_i(gie_i),
        .txc_irq_taken_i(taken_i), .txe_irq_o(txe_irq_o), .txc_irq_o(txc_irq_o), .rxc_irq_o(rxc_irq_o),
        .serial_in_pin_i(rem_line), .serial_out_pin_o(out_o), .serial_out_pin_oe_o(oe_o),
        .serial_in_pin_own_o(own_o), .sync_clock_pin_i(xck_i), .baud_tick_i(baud_tick_i));
    // Released output pin falls back to the idle-high port level
    usp_remote rem_u (.clk_i(clk_i), .tick_i(baud_tick_i), .line_i(oe_o ? out_o : 1'b1), .line_o(rem_line));

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        tick_cnt <= tick_cnt + 3'h1;
        baud_tick_i <= (tick_cnt == 3'h7);
        // Sync clock rises early enough that its synchronised edge lands on the baud tick
        xck_i <= (tick_cnt >= 3'h3) && (tick_cnt != 3'h7);
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        sel_i <= 4'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        if (ack_o !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, ack_o, 1'b1);
        end
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        sel_i <= 4'h0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk({4'h0, q & m}, {4'h0, e});
    endtask

    task automatic t_reset;
        rd(ADR_STATUS, 8'hff, 8'h20);
        rd(ADR_CONTROL, 8'hff, CONTROL_RST);
        rd(ADR_FORMAT, 8'hff, FORMAT_RST);
        chk({11'h0, oe_o}, 12'h0);
        $display("t_reset done");
    endtask

    task automatic t_tx;
        logic [11:0] b1, b2;
        wb(1'b1, ADR_FORMAT, 8'h26);
        wb(1'b1, ADR_CONTROL, 8'h08);
        fork
            begin
                rem_u.grab(b1, 10);
                rem_u.grab(b2, 10);
            end
            begin
                wb(1'b1, ADR_DATA, 8'ha5);
                wb(1'b1, ADR_DATA, 8'h3c);
                rd(ADR_STATUS, 8'h60, 8'h00);
                // Disable while a character still waits: both frames must go out
                wb(1'b1, ADR_CONTROL, 8'h00);
            end
        join
        chk(b1, {2'h0, 1'b1, ^8'ha5, 8'ha5});
        chk(b2, {2'h0, 1'b1, ^8'h3c, 8'h3c});
        repeat (20) @(posedge clk_i);
        rd(ADR_STATUS, 8'h60, 8'h60);
        chk({11'h0, oe_o}, 12'h0);
        gie_i <= 1'b1;
        wb(1'b1, ADR_CONTROL, 8'h60);
        chk({10'h0, txc_irq_o, txe_irq_o}, 12'h3);
        taken_i <= 1'b1;
        @(posedge clk_i);
        taken_i <= 1'b0;
        rd(ADR_STATUS, 8'h60, 8'h20);
        gie_i <= 1'b0;
        @(posedge clk_i);
        chk({11'h0, txe_irq_o}, 12'h0);
        $display("t_tx done");
    endtask

    task automatic t_nine;
        logic [11:0] b;
        wb(1'b1, ADR_FORMAT, 8'h46);
        wb(1'b1, ADR_CONTROL, 8'h0d);
        fork
            rem_u.grab(b, 10);
            begin
                wb(1'b1, ADR_DATA, 8'h5a);
                wb(1'b1, ADR_CONTROL, 8'h0c);
            end
        join
        chk(b, {2'h0, 1'b1, 1'b1, 8'h5a});
        rd(ADR_STATUS, 8'h60, 8'h60);
        wb(1'b1, ADR_STATUS, 8'h40);
        rd(ADR_STATUS, 8'h60, 8'h20);
        wb(1'b1, ADR_CONTROL, 8'h00);
        $display("t_nine done");
    endtask

    task automatic t_rx;
        gie_i <= 1'b1;
        wb(1'b1, ADR_FORMAT, 8'h04);
        wb(1'b1, ADR_CONTROL, 8'h90);
        chk({11'h0, own_o}, 12'h1);
        rem_u.send({4'h1, 7'h7f, 1'b0}, 9);
        rem_u.send({4'h0, 7'h15, 1'b0}, 9);
        repeat (4) @(posedge clk_i);
        chk({11'h0, rxc_irq_o}, 12'h1);
        rd(ADR_STATUS, 8'h90, 8'h80);
        rd(ADR_DATA, 8'hff, 8'h7f);
        rd(ADR_STATUS, 8'h90, 8'h90);
        rd(ADR_DATA, 8'hff, 8'h15);
        rd(ADR_STATUS, 8'h80, 8'h00);
        rem_u.send({4'h1, 7'h2a, 1'b0}, 9);
        rd(ADR_STATUS, 8'h80, 8'h80);
        wb(1'b1, ADR_CONTROL, 8'h00);
        rd(ADR_STATUS, 8'h80, 8'h00);
        $display("t_rx done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_tx();
        t_nine();
        t_rx();
        print_verdict();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
endmodule
